// >>> verilog/gfd_pkg.sv
package gfd_pkg;
	// ==========================================================
	// sizes and clocking
	localparam int NCH      = 6;
	localparam int CLK_MHZ  = 250;
	localparam int TICK_NS  = 1000;
	localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
	localparam int BW       = 9;
	localparam int RW       = 16;

	// ==========================================================
	// blanking times in microseconds, one timer tick per microsecond
	localparam logic [BW-1:0] ON_BLANK_US  [4] = '{9'h006, 9'h00C, 9'h018, 9'h030};
	localparam logic [BW-1:0] OFF_BLANK_US [4] = '{9'h037, 9'h051, 9'h0A2, 9'h145};
	localparam int BLANK_ON_LSB  = 0;
	localparam int BLANK_OFF_LSB = 2;

	// ==========================================================
	// status codes, lower value is higher priority
	localparam logic [2:0] CODE_INVALID      = 3'h0;
	localparam logic [2:0] SHORTED_LOAD_CODE = 3'h1;
	localparam logic [2:0] SHORT_GROUND_CODE = 3'h2;
	localparam logic [2:0] OPEN_LOAD_CODE    = 3'h3;
	localparam logic [2:0] CODE_DONE_OK      = 3'h4;
	localparam logic [2:0] CODE_NO_SHORT_ON  = 3'h5;
	localparam logic [2:0] CODE_NO_FAULT_OFF = 3'h6;
	localparam logic [2:0] CODE_NOT_COMPLETE = 3'h7;

	// ==========================================================
	// configuration carried from the serial port
	typedef struct packed {
		logic [NCH-1:0]      gate_cmd_bits;
		logic [NCH-1:0]      recovery_mode_bits;
		logic [NCH-1:0][3:0] blank_sel;
		logic [NCH-1:0][2:0] short_thresh_sel;
		logic [NCH-1:0]      openload_en_bits;
	} gfd_cfg_type;

	localparam logic [NCH-1:0] GATE_CMD_RST  = 6'h00;
	localparam logic [NCH-1:0] MODE_RST      = 6'h00;
	localparam logic [3:0]     BLANK_SEL_RST = 4'hA;
	localparam logic [2:0]     THRESH_RST    = 3'h0;
	localparam logic [NCH-1:0] OL_EN_RST     = 6'h3F;
	localparam gfd_cfg_type CFG_RST = '{
		gate_cmd_bits:      GATE_CMD_RST,
		recovery_mode_bits: MODE_RST,
		blank_sel:          {NCH{BLANK_SEL_RST}},
		short_thresh_sel:   {NCH{THRESH_RST}},
		openload_en_bits:   OL_EN_RST
	};
endpackage : gfd_pkg

// >>> verilog/gfd_tick_div.sv
`timescale 1ns/1ps
module gfd_tick_div import gfd_pkg::*; #(
	parameter int DIV = TICK_CYC
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	// control
	input  wire logic i_run,
	output logic      o_tick
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q + 16'h0001;
		if (!i_run || cnt_q == 16'(DIV - 1)) begin
			cnt_d = 16'h0000;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_tick = i_run && cnt_q == 16'(DIV - 1);
endmodule : gfd_tick_div

// >>> verilog/gfd_down_timer.sv
`timescale 1ns/1ps
module gfd_down_timer import gfd_pkg::*; #(
	parameter int W = BW
) (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_reset,
	// control
	input  wire logic         i_clear,
	input  wire logic         i_start,
	input  wire logic [W-1:0] i_len,
	input  wire logic         i_tick,
	// state
	output logic              o_busy,
	output logic              o_done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// length is taken only at start, so a later change waits for the next run
	always_comb begin
		cnt_d = cnt_q;
		if (i_clear) begin
			cnt_d = '0;
		end else if (i_start) begin
			cnt_d = i_len;
		end else if (i_tick && cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_busy = cnt_q != '0;
	assign o_done = i_tick && !i_clear && cnt_q == W'(1);
endmodule : gfd_down_timer

// >>> verilog/gfd_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - gate high only with reset released, enabled, no short latch or retry, input or bit high or an on pulse running
// - master reset low forces gates low, stops timers, restores defaults, clears status
// - disable high forces gates low, stops diagnostics and retry, keeps data
// - drive change starts on or off blanking, drain sampled at its end
// - comparator change in stable state starts filter, also allowed during blanking
// - each channel has own blanking and filter timers; blanking length per channel, filter common
// - blanking selection rewritten mid-run applies from next activation only
// - all blanking timers start on power-up, reset release or enable
// - on-state fault protects the switch; any fault sets flag and status
// - three-bit status latches higher priority, never demoted
// - status returns to not-complete on read or master reset, kept on disable
// - diagnostics off under reset or disable, else open load per enable bit
// - requested diagnostic pulse runs at chip select rising edge, either mode
// - pulse suppressed when disabled, both requested, shorted, busy or retrying
// - off pulse forces open load check, inverts output for off blanking
// - on pulse inverts output for on blanking, then restores commanded state
// - shorted-load threshold picked per channel from eight reference ratios
// - shorted load registered when drain above reference after blanking or filter
// - latch-off mode default; recover by enable toggle or read then pulse
// - auto-retry holds gate off for retry time, stopped by disable or latch-off
// - one global retry timer, started by the first faulted channel
// - off state: above open-load ok, below ground ref short, between open
// - on blanking 6/12/24/48 us, off blanking 55/81/162/325 us
// - status codes 001 to 111 as listed, 000 invalid
// - open-load enable bits all one after reset
// - fault flag low on fault only with reset and select high, disable low
module gfd_ctrl import gfd_pkg::*; #(
	parameter int FILTER_US = 10,
	parameter int RETRY_US  = 10000
) (
	// clock and reset
	input  wire logic                i_core_clk,
	input  wire logic                i_reset,
	// host control pins
	input  wire logic                i_master_reset_n,
	input  wire logic                i_global_disable,
	input  wire logic                i_chip_select_n,
	input  wire logic [NCH-1:0]      i_par_in,
	// serial port side
	input  wire logic                i_cfg_load,
	input  wire gfd_cfg_type         i_cfg,
	input  wire logic [NCH-1:0]      i_off_pulse_req,
	input  wire logic [NCH-1:0]      i_on_pulse_req,
	input  wire logic [NCH-1:0]      i_status_clr,
	// drain comparators
	input  wire logic [NCH-1:0]      i_drain_above_short,
	input  wire logic [NCH-1:0]      i_drain_above_ol,
	input  wire logic [NCH-1:0]      i_drain_below_sg,
	// outputs
	output logic [NCH-1:0]           o_gate_out,
	output logic [NCH-1:0][2:0]      o_short_thresh_sel,
	output logic [NCH-1:0][2:0]      o_status,
	output logic                     o_fault_flag_n_out,
	output logic                     o_fault_flag_n_oe_n
);
	// ==========================================================
	// state
	gfd_cfg_type         cfg_q, cfg_d;
	logic [NCH-1:0][2:0] status_q, status_d;
	logic [NCH-1:0]      short_latch_n_q, short_latch_n_d;
	logic [NCH-1:0]      retry_q, retry_d;
	logic [NCH-1:0]      pulse_q, pulse_d;
	logic [NCH-1:0]      pulse_lvl_q, pulse_lvl_d;
	logic [NCH-1:0]      drv_q, drv_d;
	logic [NCH-1:0]      abn_q, abn_d;
	logic [NCH-1:0]      gate_q, gate_d;
	logic                run_q, cs_q, flag_oe_n_q, flag_oe_n_d;

	// ==========================================================
	// combinational helpers
	logic                run, start_all, cs_rise, any_fault, retry_start;
	logic                tick, retry_busy, retry_done;
	logic [NCH-1:0]      cmd, blank_start, filt_start, blank_busy, blank_done, filt_done;
	logic [NCH-1:0]      ol_en, sample;
	logic [NCH-1:0][2:0] code;
	logic [NCH-1:0][BW-1:0] blank_len;

	// ==========================================================
	// timers
	gfd_tick_div u_tick (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_run      (i_master_reset_n),
		.o_tick     (tick)
	);

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		gfd_down_timer #(.W(BW)) u_blank (
			.i_core_clk (i_core_clk),
			.i_reset    (i_reset),
			.i_clear    (!run),
			.i_start    (blank_start[g]),
			.i_len      (blank_len[g]),
			.i_tick     (tick),
			.o_busy     (blank_busy[g]),
			.o_done     (blank_done[g])
		);
		gfd_down_timer #(.W(BW)) u_filt (
			.i_core_clk (i_core_clk),
			.i_reset    (i_reset),
			.i_clear    (!run),
			.i_start    (filt_start[g]),
			.i_len      (BW'(FILTER_US)),
			.i_tick     (tick),
			.o_busy     (),
			.o_done     (filt_done[g])
		);
	end

	gfd_down_timer #(.W(RW)) u_retry (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_clear    (!run),
		.i_start    (retry_start),
		.i_len      (RW'(RETRY_US)),
		.i_tick     (tick),
		.o_busy     (retry_busy),
		.o_done     (retry_done)
	);

	// ==========================================================
	// channel logic
	always_comb begin
		cfg_d           = cfg_q;
		status_d        = status_q;
		short_latch_n_d = short_latch_n_q;
		retry_d         = retry_q;
		pulse_d         = pulse_q;
		pulse_lvl_d     = pulse_lvl_q;
		abn_d           = abn_q;
		run             = i_master_reset_n && !i_global_disable;
		start_all       = run && !run_q;
		cs_rise         = i_chip_select_n && !cs_q;
		any_fault       = 1'b0;
		if (i_master_reset_n && i_cfg_load) begin
			cfg_d = i_cfg;
		end
		// every retrying channel is released together when the period ends
		if (retry_done) begin
			retry_d = '0;
		end
		for (int i = 0; i < NCH; i++) begin
			cmd[i]  = i_par_in[i] || cfg_q.gate_cmd_bits[i];
			drv_d[i] = (pulse_q[i] ? pulse_lvl_q[i] : cmd[i])
				&& short_latch_n_q[i] && !retry_q[i];
			blank_start[i] = run && (start_all || drv_d[i] != drv_q[i]);
			blank_len[i] = drv_d[i]
				? ON_BLANK_US[cfg_q.blank_sel[i][BLANK_ON_LSB +: 2]]
				: OFF_BLANK_US[cfg_q.blank_sel[i][BLANK_OFF_LSB +: 2]];
			ol_en[i] = cfg_q.openload_en_bits[i]
				|| (pulse_q[i] && !pulse_lvl_q[i]);
			abn_d[i] = drv_q[i] ? i_drain_above_short[i]
				: (i_drain_below_sg[i] || (!i_drain_above_ol[i] && ol_en[i]));
			filt_start[i] = run && abn_d[i] != abn_q[i];
			sample[i] = run && (blank_done[i] || filt_done[i]);
			if (drv_q[i]) begin
				code[i] = i_drain_above_short[i] ? SHORTED_LOAD_CODE
					: CODE_NO_SHORT_ON;
			end else if (i_drain_below_sg[i]) begin
				code[i] = SHORT_GROUND_CODE;
			end else if (!i_drain_above_ol[i] && ol_en[i]) begin
				code[i] = OPEN_LOAD_CODE;
			end else begin
				code[i] = CODE_NO_FAULT_OFF;
			end
			// a read clear and a new code in one cycle keep the new code
			if (i_status_clr[i]) begin
				status_d[i] = CODE_NOT_COMPLETE;
			end
			if (sample[i] && code[i] < status_d[i]) begin
				status_d[i] = code[i];
			end
			if (sample[i] && code[i] == SHORTED_LOAD_CODE) begin
				if (cfg_q.recovery_mode_bits[i]) begin
					retry_d[i] = 1'b1;
				end else begin
					short_latch_n_d[i] = 1'b0;
				end
			end
			if (!cfg_q.recovery_mode_bits[i]) begin
				retry_d[i] = 1'b0;
			end
			if (pulse_q[i] && blank_done[i]) begin
				pulse_d[i] = 1'b0;
			end
			if (cs_rise && (i_on_pulse_req[i] || i_off_pulse_req[i])
				&& !(i_on_pulse_req[i] && i_off_pulse_req[i]) && !i_global_disable
				&& status_q[i] != SHORTED_LOAD_CODE && !pulse_q[i]
				&& !blank_busy[i] && !retry_busy && i_master_reset_n) begin
				pulse_d[i]         = 1'b1;
				pulse_lvl_d[i]     = i_on_pulse_req[i];
				short_latch_n_d[i] = 1'b1;
				// pulse always runs a blanking period, even with no level change
				blank_start[i]     = 1'b1;
			end
			if (status_q[i] == SHORTED_LOAD_CODE || status_q[i] == SHORT_GROUND_CODE
				|| status_q[i] == OPEN_LOAD_CODE) begin
				any_fault = 1'b1;
			end
		end
		retry_start = (|(retry_d & ~retry_q)) && (!retry_busy || retry_done);
		// disable releases latched channels and stops any retry or pulse
		if (i_global_disable) begin
			short_latch_n_d = '1;
			retry_d         = '0;
			pulse_d         = '0;
		end
		// master reset low: defaults, serial gate bits cleared, status cleared
		if (!i_master_reset_n) begin
			cfg_d           = CFG_RST;
			status_d        = {NCH{CODE_NOT_COMPLETE}};
			short_latch_n_d = '1;
			retry_d         = '0;
			pulse_d         = '0;
			pulse_lvl_d     = '0;
		end
		gate_d = run ? drv_d : '0;
		flag_oe_n_d = !(i_master_reset_n && i_chip_select_n && !i_global_disable
			&& any_fault);
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg_q           <= CFG_RST;
			status_q        <= {NCH{CODE_NOT_COMPLETE}};
			short_latch_n_q <= '1;
			retry_q         <= '0;
			pulse_q         <= '0;
			pulse_lvl_q     <= '0;
			drv_q           <= '0;
			abn_q           <= '0;
			gate_q          <= '0;
			run_q           <= 1'b0;
			cs_q            <= 1'b1;
			flag_oe_n_q     <= 1'b1;
			o_fault_flag_n_out <= 1'b0;
		end else begin
			cfg_q           <= cfg_d;
			status_q        <= status_d;
			short_latch_n_q <= short_latch_n_d;
			retry_q         <= retry_d;
			pulse_q         <= pulse_d;
			pulse_lvl_q     <= pulse_lvl_d;
			drv_q           <= drv_d;
			abn_q           <= abn_d;
			gate_q          <= gate_d;
			run_q           <= run;
			cs_q            <= i_chip_select_n;
			flag_oe_n_q     <= flag_oe_n_d;
			o_fault_flag_n_out <= 1'b0;
		end
	end

	assign o_gate_out          = gate_q;
	assign o_status            = status_q;
	assign o_short_thresh_sel  = cfg_q.short_thresh_sel;
	assign o_fault_flag_n_oe_n = flag_oe_n_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	AST_GATE_NEEDS_RUN: assert property (|o_gate_out |-> $past(run))
		else $error("gate high without reset release and enable");
	AST_GATE_RESET_LOW: assert property (!i_master_reset_n [*2] |-> o_gate_out == '0)
		else $error("gate high during master reset");
	AST_GATE_DISABLED: assert property (i_global_disable |=> o_gate_out == '0)
		else $error("gate high while disabled");
	AST_NO_DEMOTE: assert property (status_q[0] == SHORTED_LOAD_CODE && i_master_reset_n
		&& !i_status_clr[0] |=> status_q[0] == SHORTED_LOAD_CODE)
		else $error("shorted load code demoted");
	AST_STATUS_RESET: assert property (!i_master_reset_n |=> o_status
		== {NCH{CODE_NOT_COMPLETE}} && cfg_q.openload_en_bits == OL_EN_RST)
		else $error("status or defaults not restored");
	AST_FLAG_CS: assert property (!i_chip_select_n |=> o_fault_flag_n_oe_n)
		else $error("fault flag pulled with select low");
	AST_CMD_CLEAR: assert property ($fell(i_master_reset_n) |=> cfg_q.gate_cmd_bits == '0)
		else $error("serial gate bits kept over reset");
	AST_RETRY_HOLD: assert property (retry_q[0] |=> !o_gate_out[0])
		else $error("gate on during retry hold");
	AST_PULSE_SUPPRESS: assert property (cs_rise && (i_global_disable || retry_busy
		|| status_q[0] == SHORTED_LOAD_CODE) |=> !$rose(pulse_q[0]))
		else $error("diagnostic pulse not suppressed");
	AST_LATCH_OFF: assert property (sample[1] && code[1] == SHORTED_LOAD_CODE
		&& !cfg_q.recovery_mode_bits[1] && !cs_rise && !i_global_disable
		&& i_master_reset_n |=> ##1 !o_gate_out[1])
		else $error("shorted channel not latched off");
	AST_PULSE_BOTH: assert property (cs_rise && i_on_pulse_req[4] && i_off_pulse_req[4]
		|=> !$rose(pulse_q[4]))
		else $error("pulse run with both requests");
	AST_STATUS_CLEAR: assert property (i_status_clr[4] && !sample[4]
		|=> o_status[4] == CODE_NOT_COMPLETE)
		else $error("status not cleared after read");
	AST_FLAG_DISABLE: assert property (i_global_disable |=> o_fault_flag_n_oe_n)
		else $error("fault flag pulled while disabled");

	COV_PULSE: cover property ($rose(pulse_q[0]) ##[1:400] $fell(pulse_q[0]));
	COV_RETRY: cover property ($rose(retry_q[0]) ##[1:1000] $fell(retry_q[0]));
	COV_OPEN:  cover property (status_q[0] == OPEN_LOAD_CODE && !o_fault_flag_n_oe_n);
endmodule : gfd_ctrl

// >>> verification/gfd_load_model.sv
`timescale 1ns/1ps
module gfd_load_model import gfd_pkg::*; (
	// gate drive from the block
	input  wire logic [NCH-1:0]      i_gate,
	// per channel: 0 healthy, 1 shorted, 2 to ground, 3 open
	input  wire logic [NCH-1:0][1:0] i_fault,
	// comparator levels
	output logic [NCH-1:0]           o_above_short,
	output logic [NCH-1:0]           o_above_ol,
	output logic [NCH-1:0]           o_below_sg
);
	// ==========================================================
	// drain levels
	// no settling delay: the block's timers are what hide edges
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			o_above_short[c] = i_gate[c] && (i_fault[c] == 2'h1);
			o_above_ol[c]    = !i_gate[c] && (i_fault[c] < 2'h2);
			o_below_sg[c]    = !i_gate[c] && (i_fault[c] == 2'h2);
		end
	end
endmodule : gfd_load_model

// >>> verification/gfd_ctrl_bench.sv
`timescale 1ns/1ps
module gfd_ctrl_bench import gfd_pkg::*;;
	// ==========================================================
	// signals
	logic                 core_clk = 1'b0;
	logic                 reset    = 1'b1;
	logic                 mrst_n   = 1'b1;
	logic                 dis      = 1'b1;
	logic                 cs_n     = 1'b1;
	logic [NCH-1:0]       par_in   = '0;
	logic                 cfg_load = 1'b0;
	gfd_cfg_type          cfg      = CFG_RST;
	logic [NCH-1:0]       off_req  = '0;
	logic [NCH-1:0]       on_req   = '0;
	logic [NCH-1:0]       st_clr   = '0;
	logic [NCH-1:0][1:0]  fault    = '{2'h3, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
	logic [NCH-1:0]       a_short;
	logic [NCH-1:0]       a_ol;
	logic [NCH-1:0]       b_sg;
	logic [NCH-1:0]       gate;
	logic [NCH-1:0][2:0]  thr;
	logic [NCH-1:0][2:0]  status;
	logic                 ff_out;
	logic                 ff_oe_n;
	logic                 flag_n;
	int                   err_total   = 0;
	int                   checks_done = 0;

	// open-drain flag with pull-up
	assign flag_n = ff_oe_n ? 1'b1 : ff_out;

	always #2 core_clk = ~core_clk;

	// short filter and retry keep the run brief
	gfd_ctrl #(.FILTER_US(2), .RETRY_US(20)) uut (
		.i_core_clk(core_clk), .i_reset(reset), .i_master_reset_n(mrst_n),
		.i_global_disable(dis), .i_chip_select_n(cs_n), .i_par_in(par_in),
		.i_cfg_load(cfg_load), .i_cfg(cfg), .i_off_pulse_req(off_req),
		.i_on_pulse_req(on_req), .i_status_clr(st_clr),
		.i_drain_above_short(a_short), .i_drain_above_ol(a_ol),
		.i_drain_below_sg(b_sg), .o_gate_out(gate), .o_short_thresh_sel(thr),
		.o_status(status), .o_fault_flag_n_out(ff_out), .o_fault_flag_n_oe_n(ff_oe_n)
	);

	gfd_load_model load (
		.i_gate(gate), .i_fault(fault), .o_above_short(a_short),
		.o_above_ol(a_ol), .o_below_sg(b_sg)
	);

	// ==========================================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic load_cfg();
		cfg_load = 1'b1;
		step(1);
		cfg_load = 1'b0;
	endtask : load_cfg

	task automatic clr(input logic [NCH-1:0] m);
		st_clr = m;
		step(1);
		st_clr = '0;
		step(1);
	endtask : clr

	// host side: requests held across the select rising edge
	task automatic pulse(input logic [NCH-1:0] on_m, input logic [NCH-1:0] off_m);
		on_req  = on_m;
		off_req = off_m;
		cs_n    = 1'b0;
		step(2);
		cs_n = 1'b1;
		step(1);
		on_req  = '0;
		off_req = '0;
	endtask : pulse

	task automatic wait_gate(input int ch, input logic v, input int lim);
		int n;
		n = 0;
		while (gate[ch] !== v && n < lim) begin
			step(1);
			n++;
		end
		chk(gate[ch], v);
	endtask : wait_gate

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk(status, {NCH{CODE_NOT_COMPLETE}});
		chk(gate, 6'h00);
		chk(flag_n, 1'b1);
		chk(thr, 18'h00000);
	endtask : t_reset

	task automatic t_offdiag();
		cfg.blank_sel        = '0;
		cfg.short_thresh_sel = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
		cfg.openload_en_bits = 6'h1F;
		load_cfg();
		chk(thr, 18'h2C688);
		dis = 1'b0;
		step(14000);
		chk(status, {3'h6, 3'h6, 3'h2, 3'h3, 3'h6, 3'h6});
		chk(flag_n, 1'b0);
		cs_n = 1'b0;
		step(2);
		chk(flag_n, 1'b1);
		cs_n = 1'b1;
	endtask : t_offdiag

	task automatic t_gate();
		cfg.gate_cmd_bits = 6'h01;
		load_cfg();
		wait_gate(0, 1'b1, 4);
		dis = 1'b1;
		step(2);
		chk(gate, 6'h00);
		chk(status[3], SHORT_GROUND_CODE);
		dis = 1'b0;
		wait_gate(0, 1'b1, 4);
		cfg.gate_cmd_bits = 6'h00;
		load_cfg();
		step(14000);
	endtask : t_gate

	task automatic t_short();
		par_in[1] = 1'b1;
		wait_gate(1, 1'b1, 4);
		step(1600);
		chk(status[1], SHORTED_LOAD_CODE);
		chk(gate[1], 1'b0);
		chk(flag_n, 1'b0);
		par_in[1] = 1'b0;
		// let the off blanking after the latch run out first
		step(14000);
		pulse(6'h02, 6'h00);
		step(20);
		chk(gate[1], 1'b0);
		clr(6'h02);
		pulse(6'h02, 6'h00);
		wait_gate(1, 1'b1, 4);
	endtask : t_short

	task automatic t_pulse();
		clr(6'h10);
		chk(status[4], CODE_NOT_COMPLETE);
		pulse(6'h10, 6'h10);
		step(20);
		chk(gate[4], 1'b0);
		pulse(6'h10, 6'h00);
		wait_gate(4, 1'b1, 4);
		step(1240);
		chk(gate[4], 1'b1);
		wait_gate(4, 1'b0, 300);
		chk(status[4], CODE_NO_SHORT_ON);
		clr(6'h20);
		pulse(6'h00, 6'h20);
		step(14000);
		chk(status[5], OPEN_LOAD_CODE);
	endtask : t_pulse

	task automatic t_retry();
		cfg.recovery_mode_bits = 6'h01;
		load_cfg();
		fault[0]  = 2'h1;
		par_in[0] = 1'b1;
		wait_gate(0, 1'b1, 4);
		wait_gate(0, 1'b0, 1700);
		pulse(6'h01, 6'h00);
		step(4000);
		chk(gate[0], 1'b0);
		wait_gate(0, 1'b1, 1200);
		par_in[0] = 1'b0;
		fault[0]  = 2'h0;
	endtask : t_retry

	task automatic t_mreset();
		cfg.gate_cmd_bits = 6'h08;
		load_cfg();
		wait_gate(3, 1'b1, 4);
		mrst_n = 1'b0;
		step(3);
		chk(gate, 6'h00);
		chk(status, {NCH{CODE_NOT_COMPLETE}});
		chk(thr, 18'h00000);
		mrst_n = 1'b1;
		step(10);
		chk(gate, 6'h00);
	endtask : t_mreset

	// ==========================================================
	// run control
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	initial begin
		step(20);
		reset = 1'b0;
		step(2);
		t_reset();
		t_offdiag();
		t_gate();
		t_short();
		t_pulse();
		t_retry();
		t_mreset();
		final_report();
	end

	// well past the expected run length
	initial begin
		#400000;
		err_total++;
		final_report();
	end
endmodule : gfd_ctrl_bench
